// ==== logic/pfc_host.sv ====
/*
 * host controller: unlock command sequences, toggle and poll waits.
 * Assumes flash pins are synchronous to clk_in.
 */
`timescale 1ns/1ns
module pfc_host #(
    parameter int POLL_LIMIT = pfc_pkg::POLL_LIMIT_CYC
) (
    input wire logic clk_in, // controller clock
    input wire logic reset_in, // async reset, high
    input wire logic req_in, // operation request, taken when ready
    input wire logic [2:0] op_in, // operation code
    input wire logic [17:0] addr_in, // target address
    input wire logic [7:0] wdata_in, // program data
    output logic ready_out, // idle and accepting
    output logic done_out, // one-cycle completion pulse
    output logic [7:0] rdata_out, // read or status data
    output logic error_out, // refused or timed out, with done
    output logic [17:0] address_lines_out, // flash address
    output logic chip_select_n_out, // flash chip select
    output logic output_drive_n_out, // flash output drive
    output logic write_strobe_n_out, // flash write strobe
    output logic [7:0] data_lines_out, // data to flash
    output logic data_lines_oe_out, // high while driving data
    input wire logic [7:0] data_lines_in // data from flash
);
    typedef enum logic [4:0] {
        PFC_IDLE = 5'b00001,
        PFC_SEQ = 5'b00010,
        PFC_POLL = 5'b00100,
        PFC_READ = 5'b01000,
        PFC_FINISH = 5'b10000
    } pfc_state_t;

    pfc_state_t state;
    logic [2:0] op;
    logic [17:0] addr;
    logic [7:0] wdata;
    logic [2:0] step;
    logic started;
    logic have_prev;
    logic [7:0] prev;
    logic [31:0] polls;
    logic bad;
    logic cyc_done;
    logic [7:0] cyc_rdata;

    // sequence table: step index gives cycle address and data
    logic [17:0] seq_addr;
    logic [7:0] seq_data;
    logic [2:0] seq_len;
    wire logic is_six = (op == pfc_pkg::OP_ERASE) ||
        (op == pfc_pkg::OP_LOCKOUT);
    wire logic [7:0] last_cmd =
        (op == pfc_pkg::OP_ERASE) ? pfc_pkg::CMD_CHIP_ERASE :
        (op == pfc_pkg::OP_LOCKOUT) ? pfc_pkg::CMD_LOCKOUT :
        (op == pfc_pkg::OP_PROGRAM) ? pfc_pkg::CMD_PROGRAM :
        (op == pfc_pkg::OP_ID_ENTRY) ? pfc_pkg::CMD_ID_ENTRY :
        pfc_pkg::CMD_ID_EXIT;
    always_comb begin
        seq_len = is_six ? 3'd6 :
            (op == pfc_pkg::OP_PROGRAM) ? 3'd4 :
            (op == pfc_pkg::OP_ID_EXIT_SHORT) ? 3'd1 : 3'd3;
        seq_addr = pfc_pkg::UNLOCK_ADDR_1;
        seq_data = pfc_pkg::UNLOCK_DATA_1;
        case (step)
            3'd1, 3'd4: begin
                seq_addr = pfc_pkg::UNLOCK_ADDR_2;
                seq_data = pfc_pkg::UNLOCK_DATA_2;
            end
            3'd2: seq_data = is_six ? pfc_pkg::CMD_SETUP : last_cmd;
            3'd5: seq_data = last_cmd;
            default: ;
        endcase
        if (step == 3'd3 && op == pfc_pkg::OP_PROGRAM) begin
            seq_addr = addr;
            seq_data = wdata;
        end
        if (op == pfc_pkg::OP_ID_EXIT_SHORT) begin
            seq_addr = addr; // any address works for single exit
            seq_data = pfc_pkg::CMD_ID_EXIT;
        end
    end

    // boot block programs are refused up front once locked, since the
    // flash would silently ignore them and polling would mislead
    wire logic in_boot = (addr_in >= pfc_pkg::BOOT_FIRST) &&
        (addr_in <= pfc_pkg::BOOT_LAST);
    logic locked_seen;
    wire logic refuse = (op_in == pfc_pkg::OP_PROGRAM) && in_boot &&
        locked_seen;
    wire logic is_poll_op = (op == pfc_pkg::OP_PROGRAM) ||
        (op == pfc_pkg::OP_ERASE) || (op == pfc_pkg::OP_LOCKOUT);
    wire logic is_read_op = (op == pfc_pkg::OP_READ) ||
        (op == pfc_pkg::OP_LOCK_QUERY);
    wire logic in_seq = (state == PFC_SEQ);
    wire logic [17:0] cyc_addr = in_seq ? seq_addr :
        (op == pfc_pkg::OP_LOCK_QUERY) ? pfc_pkg::LOCK_STATUS_ADDR : addr;
    wire logic cyc_start = (state != PFC_IDLE) &&
        (state != PFC_FINISH) && !started;
    // toggle bit frozen across two reads means the flash is done
    wire logic toggle_still = have_prev &&
        (prev[pfc_pkg::TOGGLE_BIT] == cyc_rdata[pfc_pkg::TOGGLE_BIT]);
    // program also checks polled bit matches written data
    wire logic poll_true = (op != pfc_pkg::OP_PROGRAM) ||
        (cyc_rdata[pfc_pkg::POLL_BIT] == wdata[pfc_pkg::POLL_BIT]);
    wire logic poll_end = toggle_still && poll_true;
    wire logic poll_timeout = (polls >= 32'(POLL_LIMIT));
    wire logic seq_last = (step == seq_len - 3'd1);

    pfc_bus_cycle u_cycle (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .start_in(cyc_start),
        .write_in(in_seq),
        .addr_in(cyc_addr),
        .wdata_in(seq_data),
        .done_out(cyc_done),
        .rdata_out(cyc_rdata),
        .address_lines_out(address_lines_out),
        .chip_select_n_out(chip_select_n_out),
        .output_drive_n_out(output_drive_n_out),
        .write_strobe_n_out(write_strobe_n_out),
        .data_lines_out(data_lines_out),
        .data_lines_oe_out(data_lines_oe_out),
        .data_lines_in(data_lines_in)
    );

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state <= PFC_IDLE;
            op <= pfc_pkg::OP_READ;
            addr <= 18'h0_0000;
            wdata <= 8'h00;
            step <= 3'd0;
            started <= 1'b0;
            have_prev <= 1'b0;
            prev <= 8'h00;
            polls <= 32'h0000_0000;
            bad <= 1'b0;
            locked_seen <= 1'b0;
            ready_out <= 1'b0;
            done_out <= 1'b0;
            rdata_out <= 8'h00;
            error_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            started <= (started || cyc_start) && !cyc_done;
            case (state)
                PFC_IDLE: begin
                    ready_out <= 1'b1;
                    if (req_in && ready_out) begin
                        ready_out <= 1'b0;
                        op <= op_in;
                        addr <= addr_in;
                        wdata <= wdata_in;
                        step <= 3'd0;
                        have_prev <= 1'b0;
                        polls <= 32'h0000_0000;
                        bad <= refuse;
                        if (refuse) begin
                            state <= PFC_FINISH;
                        end else if (op_in == pfc_pkg::OP_READ ||
                                     op_in == pfc_pkg::OP_LOCK_QUERY) begin
                            state <= PFC_READ;
                        end else begin
                            state <= PFC_SEQ;
                        end
                    end
                end
                PFC_SEQ: begin
                    if (cyc_done) begin
                        step <= step + 3'd1;
                        if (seq_last) begin
                            state <= is_poll_op ? PFC_POLL : PFC_FINISH;
                            if (op == pfc_pkg::OP_LOCKOUT) begin
                                locked_seen <= 1'b1;
                            end
                        end
                    end
                end
                PFC_POLL: begin
                    // flash times program and erase itself; we only watch
                    if (cyc_done) begin
                        prev <= cyc_rdata;
                        have_prev <= 1'b1;
                        polls <= polls + 32'h0000_0001;
                        if (poll_end) begin
                            state <= PFC_FINISH;
                        end else if (poll_timeout) begin
                            bad <= 1'b1;
                            state <= PFC_FINISH;
                        end
                    end
                end
                PFC_READ: begin
                    if (cyc_done) begin
                        rdata_out <= cyc_rdata;
                        if (op == pfc_pkg::OP_LOCK_QUERY &&
                            cyc_rdata[pfc_pkg::LOCK_STATUS_BIT]) begin
                            locked_seen <= 1'b1;
                        end
                        state <= PFC_FINISH;
                    end
                end
                PFC_FINISH: begin
                    if (is_poll_op && !bad) begin
                        rdata_out <= prev;
                    end
                    error_out <= bad;
                    done_out <= 1'b1;
                    state <= PFC_IDLE;
                end
                default: state <= PFC_IDLE;
            endcase
            if (is_read_op && state == PFC_IDLE) begin
                error_out <= 1'b0;
            end
        end
    end
endmodule : pfc_host

// ==== inc/pfc_pkg.sv ====
/* command codes, boot bounds and pin timing for the flash host.
   Assumes a 25 MHz controller clock. */
package pfc_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 8;
    localparam logic [17:0] UNLOCK_ADDR_1 = 18'h0_5555;
    localparam logic [17:0] UNLOCK_ADDR_2 = 18'h0_2AAA;
    localparam logic [7:0] UNLOCK_DATA_1 = 8'hAA;
    localparam logic [7:0] UNLOCK_DATA_2 = 8'h55;
    localparam logic [7:0] CMD_SETUP = 8'h80;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [7:0] CMD_LOCKOUT = 8'h40;
    localparam logic [7:0] CMD_PROGRAM = 8'hA0;
    localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
    localparam logic [7:0] CMD_ID_EXIT = 8'hF0;
    localparam logic [17:0] BOOT_FIRST = 18'h0_0000;
    localparam logic [17:0] BOOT_LAST = 18'h0_1FFF;
    localparam logic [17:0] LOCK_STATUS_ADDR = 18'h0_0002;
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    localparam int LOCK_STATUS_BIT = 0;
    // operation codes on the user command port
    localparam logic [2:0] OP_READ = 3'h0;
    localparam logic [2:0] OP_PROGRAM = 3'h1;
    localparam logic [2:0] OP_ERASE = 3'h2;
    localparam logic [2:0] OP_LOCKOUT = 3'h3;
    localparam logic [2:0] OP_ID_ENTRY = 3'h4;
    localparam logic [2:0] OP_ID_EXIT = 3'h5;
    localparam logic [2:0] OP_ID_EXIT_SHORT = 3'h6;
    localparam logic [2:0] OP_LOCK_QUERY = 3'h7;
    // pin and operation timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int STROBE_LOW_NS = 100;
    localparam int STROBE_LOW_CYC =
        (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_ACCESS_NS = 120;
    localparam int READ_ACCESS_CYC =
        (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_NS = 40;
    localparam int RECOVER_CYC =
        (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BYTE_PROGRAM_US = 50;
    localparam int ERASE_S = 10;
    localparam int POLL_LIMIT_CYC = 1000;
endpackage : pfc_pkg

// ==== logic/pfc_bus_cycle.sv ====
/*
 * One flash bus cycle: a write (strobe pulse) or a read (output drive
 * pulse, data sampled at its end). Assumes flash pins sync to clk_in.
 */
`timescale 1ns/1ns
module pfc_bus_cycle (
    input wire logic clk_in, // controller clock
    input wire logic reset_in, // async reset, high
    input wire logic start_in, // begin one cycle
    input wire logic write_in, // 1 write, 0 read
    input wire logic [17:0] addr_in, // cycle address
    input wire logic [7:0] wdata_in, // write data
    output logic done_out, // one-cycle pulse at end
    output logic [7:0] rdata_out, // sampled read data
    output logic [17:0] address_lines_out, // flash address
    output logic chip_select_n_out, // flash chip select
    output logic output_drive_n_out, // flash output drive
    output logic write_strobe_n_out, // flash write strobe
    output logic [7:0] data_lines_out, // data driven to flash
    output logic data_lines_oe_out, // high while driving
    input wire logic [7:0] data_lines_in // data from flash
);
    typedef enum logic [3:0] {
        PFB_IDLE = 4'b0001,
        PFB_WRITE = 4'b0010,
        PFB_READ = 4'b0100,
        PFB_GAP = 4'b1000
    } pfb_state_t;

    pfb_state_t state;
    logic [7:0] count;
    wire logic count_zero = (count == 8'h00);

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state <= PFB_IDLE;
            count <= 8'h00;
            done_out <= 1'b0;
            rdata_out <= 8'h00;
            address_lines_out <= 18'h0_0000;
            chip_select_n_out <= 1'b1;
            output_drive_n_out <= 1'b1;
            write_strobe_n_out <= 1'b1;
            data_lines_out <= 8'h00;
            data_lines_oe_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            count <= count - 8'h01;
            case (state)
                PFB_IDLE: begin
                    if (start_in) begin
                        address_lines_out <= addr_in;
                        chip_select_n_out <= 1'b0;
                        if (write_in) begin
                            // output drive stays high: low would inhibit
                            data_lines_out <= wdata_in;
                            data_lines_oe_out <= 1'b1;
                            write_strobe_n_out <= 1'b0;
                            // pulse well over the glitch filter width
                            count <= 8'(pfc_pkg::STROBE_LOW_CYC);
                            state <= PFB_WRITE;
                        end else begin
                            output_drive_n_out <= 1'b0;
                            count <= 8'(pfc_pkg::READ_ACCESS_CYC);
                            state <= PFB_READ;
                        end
                    end
                end
                PFB_WRITE: begin
                    if (count_zero) begin
                        // data held through the rising strobe edge
                        write_strobe_n_out <= 1'b1;
                        chip_select_n_out <= 1'b1;
                        count <= 8'(pfc_pkg::RECOVER_CYC);
                        state <= PFB_GAP;
                    end
                end
                PFB_READ: begin
                    if (count_zero) begin
                        rdata_out <= data_lines_in;
                        output_drive_n_out <= 1'b1;
                        chip_select_n_out <= 1'b1;
                        count <= 8'(pfc_pkg::RECOVER_CYC);
                        state <= PFB_GAP;
                    end
                end
                PFB_GAP: begin
                    data_lines_oe_out <= 1'b0;
                    if (count_zero) begin
                        done_out <= 1'b1;
                        state <= PFB_IDLE;
                    end
                end
                default: state <= PFB_IDLE;
            endcase
        end
    end
endmodule : pfc_bus_cycle

// ==== verif/pfc_host_properties.sv ====
/* port checker for pfc_host, bound after the module.
   assumes pfc_pkg is compiled first and pins sync to clk_in. */
`timescale 1ns/1ns
module pfc_host_checker (
    input wire logic clk_in, // clock
    input wire logic reset_in, // reset, high
    input wire logic ready_out, // idle
    input wire logic done_out, // done pulse
    input wire logic error_out, // error
    input wire logic [17:0] address_lines_out, // flash address
    input wire logic chip_select_n_out, // select
    input wire logic output_drive_n_out, // output drive
    input wire logic write_strobe_n_out, // strobe
    input wire logic [7:0] data_lines_out, // host data
    input wire logic data_lines_oe_out // host drives
);
    logic we_q;
    logic [17:0] prev_a;
    logic [7:0] prev_d;
    wire wr_fall = we_q & ~write_strobe_n_out;
    wire [7:0] wd = data_lines_out;
    wire at_u1 = address_lines_out == pfc_pkg::UNLOCK_ADDR_1;
    // previous write cycle, to judge command order
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            we_q <= 1'b1;
            prev_a <= 18'h0_0000;
            prev_d <= 8'h00;
        end else begin
            we_q <= write_strobe_n_out;
            if (wr_fall) begin
                prev_a <= address_lines_out;
                prev_d <= wd;
            end
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    property p_inhibit;
        !write_strobe_n_out |-> !chip_select_n_out && output_drive_n_out;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("strobe bad");
    property p_drive;
        !write_strobe_n_out |-> data_lines_oe_out;
    endproperty
    a_drive: assert property (p_drive) else $error("data undriven");
    property p_hold;
        !write_strobe_n_out && !we_q |->
            $stable(address_lines_out) && $stable(data_lines_out);
    endproperty
    a_hold: assert property (p_hold) else $error("write moved");
    property p_no_fight;
        !output_drive_n_out |-> !data_lines_oe_out;
    endproperty
    a_no_fight: assert property (p_no_fight) else $error("fight");
    property p_width;
        wr_fall |-> !write_strobe_n_out [*4];
    endproperty
    a_width: assert property (p_width) else $error("short strobe");
    property p_cmd;
        wr_fall && at_u1 && wd != pfc_pkg::UNLOCK_DATA_1 |->
            prev_a == pfc_pkg::UNLOCK_ADDR_2 &&
            prev_d == pfc_pkg::UNLOCK_DATA_2;
    endproperty
    a_cmd: assert property (p_cmd) else $error("no unlock");
    property p_setup;
        wr_fall && prev_d == pfc_pkg::CMD_SETUP |->
            at_u1 && wd == pfc_pkg::UNLOCK_DATA_1;
    endproperty
    a_setup: assert property (p_setup) else $error("bad 4th");
    property p_quiet;
        ready_out |-> chip_select_n_out && write_strobe_n_out;
    endproperty
    a_quiet: assert property (p_quiet) else $error("idle bus");
    property p_done;
        done_out |=> !done_out ##[0:1] ready_out;
    endproperty
    a_done: assert property (p_done) else $error("done bad");
    c_erase: cover property (wr_fall && wd == pfc_pkg::CMD_CHIP_ERASE);
    c_lock: cover property (wr_fall && wd == pfc_pkg::CMD_LOCKOUT);
    c_refuse: cover property (done_out && error_out);
endmodule : pfc_host_checker
bind pfc_host pfc_host_checker u_chk (
    .clk_in(clk_in), .reset_in(reset_in), .ready_out(ready_out),
    .done_out(done_out), .error_out(error_out),
    .address_lines_out(address_lines_out),
    .chip_select_n_out(chip_select_n_out),
    .output_drive_n_out(output_drive_n_out),
    .write_strobe_n_out(write_strobe_n_out),
    .data_lines_out(data_lines_out),
    .data_lines_oe_out(data_lines_oe_out));

// ==== verif/pfc_flash_model.sv ====
/* behavioural 256K x 8 flash with unlock commands and status reads.
   assumes pfc_pkg compiled first; erase time shortened by parameter. */
`timescale 1ns/1ns
module pfc_flash_model #(
    parameter int PROG_NS = 50000,
    parameter int ERASE_NS = 20000,
    parameter logic [7:0] MAKER_CODE = 8'h3C, // arbitrary value
    parameter logic [7:0] PART_CODE = 8'hC3 // arbitrary value
) (
    input wire logic [17:0] address_lines_in, // address
    input wire logic chip_select_n_in, // select, low
    input wire logic output_drive_n_in, // output drive, low
    input wire logic write_strobe_n_in, // strobe, low
    input wire logic [7:0] data_lines_in, // bus level
    output logic [7:0] data_lines_out // level seen from flash side
);
    logic [7:0] mem [0:262143];
    logic [17:0] a_q, last_a;
    logic [7:0] last_d, cur, last_out = 8'h00;
    logic busy = 1'b0, locked = 1'b0, id_mode = 1'b0;
    logic is_prog = 1'b0, tog = 1'b0;
    int step = 0;
    time t_fall;
    wire wr_n = chip_select_n_in | write_strobe_n_in |
        ~output_drive_n_in;
    wire rd_n = chip_select_n_in | output_drive_n_in | ~write_strobe_n_in;
    initial begin
        for (int i = 0; i < 262144; i++) mem[i] = 8'(i ^ (i >> 8));
    end
    always @(negedge wr_n) begin
        a_q = address_lines_in;
        t_fall = $time;
    end
    // data taken at the rising edge; short pulses filtered out
    always @(posedge wr_n) begin : decode
        logic [7:0] d;
        logic u1, u2;
        d = data_lines_in;
        u1 = a_q == pfc_pkg::UNLOCK_ADDR_1;
        u2 = a_q == pfc_pkg::UNLOCK_ADDR_2 && d == 8'h55;
        if (!busy && $time - t_fall >= 15) begin
            case (step)
                0: begin
                    if (d == pfc_pkg::CMD_ID_EXIT) id_mode = 1'b0;
                    step = (u1 && d == 8'hAA) ? 1 : 0;
                end
                1: step = u2 ? 2 : 0;
                2: begin
                    step = 0;
                    if (u1 && d == 8'h80) step = 3;
                    if (u1 && d == 8'hA0) step = 6;
                    if (u1 && d == 8'h90) id_mode = 1'b1;
                    if (u1 && d == 8'hF0) id_mode = 1'b0;
                end
                3: step = (u1 && d == 8'hAA) ? 4 : 0;
                4: step = u2 ? 5 : 0;
                5: begin
                    step = 0;
                    if (u1 && d == 8'h10) begin
                        is_prog = 1'b0;
                        busy = 1'b1;
                        busy <= #ERASE_NS 1'b0;
                    end
                    if (u1 && d == 8'h40) locked = 1'b1;
                end
                default: begin
                    step = 0;
                    if (!(locked && a_q <= pfc_pkg::BOOT_LAST)) begin
                        last_a = a_q;
                        last_d = d;
                        is_prog = 1'b1;
                        busy = 1'b1;
                        busy <= #PROG_NS 1'b0;
                    end
                end
            endcase
        end
    end
    always @(negedge busy) begin
        if (is_prog) mem[last_a] = mem[last_a] & last_d;
        else for (int i = 0; i < 262144; i++) begin
            if (!(locked && i <= 8191)) mem[i] = 8'hFF;
        end
    end
    always @(negedge rd_n) if (busy) tog = ~tog;
    always @(posedge rd_n) last_out = cur;
    always @* begin
        if (busy) cur = {is_prog ? ~last_d[7] : 1'b0, tog, 6'h00};
        else if (id_mode && address_lines_in == 18'h0_0000) cur = MAKER_CODE;
        else if (id_mode && address_lines_in == 18'h0_0001) cur = PART_CODE;
        else if (id_mode && address_lines_in == pfc_pkg::LOCK_STATUS_ADDR)
            cur = {7'h00, locked};
        else cur = mem[address_lines_in];
    end
    // released lines show the inverse of the last byte, never a stale copy
    assign data_lines_out = rd_n ? ~last_out : cur;
endmodule : pfc_flash_model

// ==== verif/pfc_host_bench.sv ====
/* self-checking bench: pfc_host against the flash model.
   assumes pfc_pkg, the design and the model are compiled first. */
`timescale 1ns/1ns
module pfc_host_bench;
    localparam logic [7:0] MAKER = 8'h3C;
    logic clk_in, reset_in, req_in, ready_out, done_out, error_out;
    logic cs_n, oe_n, we_n, d_oe, got_err;
    logic [2:0] op_in;
    logic [17:0] addr_in, a_lines;
    logic [7:0] wdata_in, rdata_out, d_host, d_flash, got;
    wire [7:0] d_bus = d_oe ? d_host : d_flash;
    int fails = 0;
    int check_count = 0;
    pfc_host uut (.clk_in(clk_in), .reset_in(reset_in), .req_in(req_in),
        .op_in(op_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .ready_out(ready_out), .done_out(done_out), .rdata_out(rdata_out),
        .error_out(error_out), .address_lines_out(a_lines),
        .chip_select_n_out(cs_n), .output_drive_n_out(oe_n),
        .write_strobe_n_out(we_n), .data_lines_out(d_host),
        .data_lines_oe_out(d_oe), .data_lines_in(d_bus));
    pfc_flash_model #(.MAKER_CODE(MAKER)) flash (.address_lines_in(a_lines),
        .chip_select_n_in(cs_n), .output_drive_n_in(oe_n),
        .write_strobe_n_in(we_n), .data_lines_in(d_bus),
        .data_lines_out(d_flash));
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    function automatic logic [7:0] pat(input logic [17:0] a);
        return a[7:0] ^ a[15:8];
    endfunction : pat
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_of_test
    task automatic chk_data(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("BAD %0t data %h want %h", $time, g, e);
        end
    endtask : chk_data
    task automatic chk_flag(input logic g, input logic e);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("BAD %0t flag %b want %b", $time, g, e);
        end
    endtask : chk_flag
    task automatic run_op(input logic [2:0] op, input logic [17:0] a,
                          input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        req_in <= 1'b1;
        op_in <= op;
        addr_in <= a;
        wdata_in <= d;
        // held to done: ready returns only after, so no second take
        while (done_out !== 1'b1 && n < 20000) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        got = rdata_out;
        got_err = error_out;
        @(posedge clk_in);
        req_in <= 1'b0;
        if (n >= 20000) begin
            fails++;
            end_of_test();
        end
    endtask : run_op
    task automatic rd(input logic [17:0] a);
        run_op(pfc_pkg::OP_READ, a, 8'h00);
    endtask : rd
    task automatic op0(input logic [2:0] op);
        run_op(op, 18'h0_0000, 8'h00);
    endtask : op0
    task automatic t_prog;
        rd(18'h0_0123);
        chk_data(got, pat(18'h0_0123));
        run_op(pfc_pkg::OP_PROGRAM, 18'h2_1234, 8'h0F);
        chk_flag(got_err, 1'b0);
        rd(18'h2_1234);
        chk_data(got, pat(18'h2_1234) & 8'h0F);
        run_op(pfc_pkg::OP_PROGRAM, 18'h2_1234, 8'hF0);
        rd(18'h2_1234);
        chk_data(got, 8'h00);
        op0(pfc_pkg::OP_ERASE);
        chk_flag(got_err, 1'b0);
        rd(18'h2_1234);
        chk_data(got, 8'hFF);
        $display("test program and erase done");
    endtask : t_prog
    task automatic t_lock;
        run_op(pfc_pkg::OP_PROGRAM, 18'h0_0010, 8'hA5);
        // lock status only reads back in id mode
        op0(pfc_pkg::OP_ID_ENTRY);
        op0(pfc_pkg::OP_LOCK_QUERY);
        chk_flag(got[0], 1'b0);
        op0(pfc_pkg::OP_ID_EXIT);
        op0(pfc_pkg::OP_LOCKOUT);
        chk_flag(got_err, 1'b0);
        op0(pfc_pkg::OP_ID_ENTRY);
        op0(pfc_pkg::OP_LOCK_QUERY);
        chk_flag(got[0], 1'b1);
        op0(pfc_pkg::OP_ID_EXIT);
        run_op(pfc_pkg::OP_PROGRAM, 18'h0_1FFF, 8'h00);
        chk_flag(got_err, 1'b1);
        run_op(pfc_pkg::OP_PROGRAM, 18'h0_2000, 8'h3C);
        chk_flag(got_err, 1'b0);
        op0(pfc_pkg::OP_ERASE);
        rd(18'h0_0010);
        chk_data(got, 8'hA5);
        rd(18'h0_2000);
        chk_data(got, 8'hFF);
        $display("test lockout done");
    endtask : t_lock
    task automatic t_id;
        op0(pfc_pkg::OP_ID_ENTRY);
        rd(18'h0_0000);
        chk_data(got, MAKER);
        op0(pfc_pkg::OP_ID_EXIT);
        rd(18'h0_0000);
        chk_data(got, 8'hFF);
        op0(pfc_pkg::OP_ID_ENTRY);
        run_op(pfc_pkg::OP_ID_EXIT_SHORT, 18'h1_0000, 8'h00);
        rd(18'h0_0000);
        chk_data(got, 8'hFF);
        $display("test identification done");
    endtask : t_id
    initial begin
        reset_in = 1'b1;
        req_in = 1'b0;
        op_in = 3'h0;
        addr_in = 18'h0_0000;
        wdata_in = 8'h00;
        repeat (12) @(posedge clk_in);
        reset_in <= 1'b0;
        t_prog();
        t_lock();
        t_id();
        end_of_test();
    end
endmodule : pfc_host_bench
